// *** pkg/pol_pkg.sv ***
// Shared command codes, field layout, timing and carrier types of the on/off and setpoint block.
`default_nettype none
package pol_pkg;
  // Command codes.
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ONOFF_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_DEF = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VNUM_FMT = 8'h20;
  localparam logic [7:0] CMD_VNOM = 8'h21;
  localparam logic [7:0] CMD_VTRIM = 8'h22;
  localparam logic [7:0] CMD_VCAL = 8'h23;
  localparam logic [7:0] CMD_VBOUND = 8'h24;
  // Bit positions of the on/off source configuration byte.
  localparam int ONOFF_PWRUP_BIT = 4;
  localparam int ONOFF_BUS_BIT = 3;
  localparam int ONOFF_PIN_BIT = 2;
  localparam int ONOFF_POL_BIT = 1;
  localparam int ONOFF_ACT_BIT = 0;
  localparam logic [15:0] ONOFF_MASK = 16'h001f;
  // Operation byte enable field.
  localparam int OP_EN_HI = 7;
  localparam int OP_EN_LO = 6;
  localparam logic [1:0] OP_OFF_NOW = 2'h0;
  localparam logic [1:0] OP_OFF_SOFT = 2'h1;
  localparam logic [1:0] OP_ON = 2'h2;
  // Voltage number format byte.
  localparam int FMT_LSB = 5;
  localparam logic [2:0] FMT_LINEAR = 3'h0;
  localparam logic [2:0] FMT_VID = 3'h1;
  localparam logic [2:0] FMT_DIRECT = 3'h2;
  localparam logic [4:0] FMT_DIRECT_LOW = 5'h00;
  // Indices of the stored configuration words.
  localparam int FLD_ONOFF = 0;
  localparam int FLD_VNOM = 1;
  localparam int FLD_VTRIM = 2;
  localparam int FLD_VCAL = 3;
  localparam int FLD_VBOUND = 4;
  localparam int NUM_FLD = 5;
  // Reset and factory values.
  localparam logic [7:0] OPERATION_RST = 8'h80;
  localparam logic [15:0] ONOFF_FACTORY = 16'h0000;
  localparam logic [15:0] OFFSET_FACTORY = 16'h0000;
  localparam logic [1:0] SEC_LEVEL_RST = 2'h0;
  localparam logic [1:0] SEC_LEVEL_USER = 2'h1;
  // Upper bound ceiling is strap times 11 / 10.
  localparam logic [19:0] BOUND_NUM = 20'h0000b;
  localparam logic [19:0] BOUND_DEN = 20'h0000a;
  // Timing.
  localparam int CLK_MHZ = 125;
  localparam int NV_WAIT_MS = 20;
  localparam int NV_WAIT_CYC = NV_WAIT_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] SYNC_SETTLE_CYC = 3'h4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } pol_cmd_t;

  typedef struct packed {
    logic run;
    logic fast_off;
    logic [15:0] target;
  } pol_ctl_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_LOAD = 2'b01,
    ST_IDLE = 2'b10,
    ST_WAIT = 2'b11
  } pol_state_t;
endpackage : pol_pkg
`default_nettype wire

// *** design/pol_vout_calc.sv ***
// Output target arithmetic: nominal plus offsets, clamped to the upper bound.
`default_nettype none
module pol_vout_calc
  import pol_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Configuration words.
  input wire logic [15:0] vnom_in,
  input wire logic [15:0] trim_in,
  input wire logic [15:0] cal_in,
  input wire logic [15:0] vbound_in,
  input wire logic [15:0] strap_in,
  // Results.
  output logic [15:0] target_out,
  output logic [15:0] ceiling_out
);
  logic [17:0] sum;
  logic [19:0] ceil_full;
  logic [15:0] nxt_target;
  logic [15:0] target_ff;

  // All words share one exponent, so the mantissas add directly.
  assign sum = {2'b00, vnom_in} + {{2{trim_in[15]}}, trim_in} + {{2{cal_in[15]}}, cal_in};
  assign ceil_full = ({4'h0, strap_in} * BOUND_NUM) / BOUND_DEN;
  assign ceiling_out = (ceil_full[19:16] != 4'h0) ? 16'hffff : ceil_full[15:0];

  always_comb begin
    if (sum[17]) begin
      nxt_target = 16'h0000;
    end else if (sum[16:0] > {1'b0, vbound_in}) begin
      nxt_target = vbound_in;
    end else begin
      nxt_target = sum[15:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      target_ff <= 16'h0000;
    end else if (ce_in) begin
      target_ff <= nxt_target;
    end
  end

  assign target_out = target_ff;
endmodule : pol_vout_calc
`default_nettype wire

// *** design/pol_onoff_vout_top.sv ***
// Command interpreter for on/off control, nonvolatile store handling and output setpoint.
`default_nettype none
// What this block does
// - Power-up bit 0 runs always; 1 waits for control pin and operation command.
// - Bus enable mode 0 ignores operation on/off field; 1 needs it commanding run.
// - Pin enable mode 0 ignores control pin; 1 needs pin asserted to start.
// - Polarity bit 0 means low level enables; 1 means high level enables.
// - Pin turn-off: action 0 gives soft off, action 1 gives fastest off.
// - Clear-faults command clears every fault status bit.
// - Store-default command copies the whole configuration into the default store.
// - Restore-default command reloads the whole configuration from the default store.
// - Store-user command saves settings changed since the latest restore.
// - Restore-user, also done at power-up, reloads user settings over the live words, or over factory at power-up.
// - Starting a user restore sets the security level to 1.
// - Format byte reports number format in bits 7:5: linear, VID or direct.
// - Format byte bits 4:0 hold exponent, VID code, or zero in direct.
// - Nominal target word sets the output target; factory value comes from strap.
// - Trim word is a signed mantissa added as a fixed output offset.
// - Calibration offset word behaves exactly like the trim word.
// - Upper bound word limits output; above 110% of strap is refused.
// - Operation 7:6: 00 immediate off, 01 soft off, 10 enable with ramp.
module pol_onoff_vout_top
  import pol_pkg::*;
#(
  parameter int unsigned NV_WAIT_CYCLES = NV_WAIT_CYC,
  parameter logic [2:0] VNUM_FMT = FMT_LINEAR,
  parameter logic [4:0] VNUM_EXP = 5'h13
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Decoded serial-bus command port.
  input wire pol_cmd_t cmd_in,
  output logic resp_valid_out,
  output logic resp_err_out,
  output logic [15:0] rd_data_out,
  output logic busy_out,
  // Pins.
  input wire logic ctrl_pin_in,
  input wire logic [15:0] voltage_select_strap_in,
  // Control loop and fault logic.
  output pol_ctl_t ctl_out,
  output logic fault_clear_out,
  output logic [1:0] security_level_out
);
  localparam int WAIT_W = $clog2(NV_WAIT_CYCLES + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(NV_WAIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  logic ctrl_meta_ff, ctrl_sync_ff;
  logic [15:0] strap_meta_ff, strap_sync_ff, strap_ff;
  pol_state_t state_ff;
  logic [2:0] init_cnt_ff;
  logic [WAIT_W-1:0] wait_cnt_ff;
  logic [7:0] op_ff;
  logic [15:0] live_ff [NUM_FLD], def_ff [NUM_FLD], usr_ff [NUM_FLD], factory [NUM_FLD];
  logic [NUM_FLD-1:0] usr_valid_ff, changed_ff;
  logic [1:0] sec_ff;
  logic run_ff, fast_off_ff, fault_clear_ff, resp_valid_ff, resp_err_ff;
  logic [15:0] rd_data_ff, target, ceiling, nxt_rd_data;
  logic idle, active, fld_hit, wr_fld, wr_op, do_clear, nv_go, req_ok;
  logic [2:0] fld_idx;
  logic do_store_def, do_restore_def, do_store_usr, do_restore_usr;
  logic pin_en, pin_off, bus_off, want_run, nxt_fast;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ctrl_meta_ff <= 1'b0;
      ctrl_sync_ff <= 1'b0;
      strap_meta_ff <= 16'h0000;
      strap_sync_ff <= 16'h0000;
    end else if (ce_in) begin
      ctrl_meta_ff <= ctrl_pin_in;
      ctrl_sync_ff <= ctrl_meta_ff;
      strap_meta_ff <= voltage_select_strap_in;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.
  assign idle = (state_ff == ST_IDLE);
  assign active = (state_ff == ST_IDLE) || (state_ff == ST_WAIT);

  always_comb begin
    fld_hit = 1'b1;
    fld_idx = 3'(FLD_ONOFF);
    case (cmd_in.code)
      CMD_ONOFF_CFG: fld_idx = 3'(FLD_ONOFF);
      CMD_VNOM: fld_idx = 3'(FLD_VNOM);
      CMD_VTRIM: fld_idx = 3'(FLD_VTRIM);
      CMD_VCAL: fld_idx = 3'(FLD_VCAL);
      CMD_VBOUND: fld_idx = 3'(FLD_VBOUND);
      default: fld_hit = 1'b0;
    endcase
  end

  assign wr_fld = idle && cmd_in.wr && fld_hit &&
                  !((fld_idx == 3'(FLD_VBOUND)) && (cmd_in.data > ceiling));
  assign wr_op = idle && cmd_in.wr && (cmd_in.code == CMD_OPERATION);
  assign do_clear = idle && cmd_in.wr && (cmd_in.code == CMD_CLEAR_FAULTS);
  assign do_store_def = idle && cmd_in.wr && (cmd_in.code == CMD_STORE_DEF);
  assign do_restore_def = idle && cmd_in.wr && (cmd_in.code == CMD_RESTORE_DEF);
  assign do_store_usr = idle && cmd_in.wr && (cmd_in.code == CMD_STORE_USER);
  assign do_restore_usr = idle && cmd_in.wr && (cmd_in.code == CMD_RESTORE_USER);
  assign nv_go = do_store_def || do_restore_def || do_store_usr || do_restore_usr;

  always_comb begin
    nxt_rd_data = 16'h0000;
    if (fld_hit) begin
      nxt_rd_data = live_ff[fld_idx];
    end else if (cmd_in.code == CMD_OPERATION) begin
      nxt_rd_data = {8'h00, op_ff};
    end else if (cmd_in.code == CMD_VNUM_FMT) begin
      nxt_rd_data = {8'h00, VNUM_FMT, (VNUM_FMT == FMT_DIRECT) ? FMT_DIRECT_LOW : VNUM_EXP};
    end
  end

  assign req_ok = idle && (cmd_in.wr ? (wr_fld || wr_op || do_clear || nv_go)
                                     : (fld_hit || (cmd_in.code == CMD_OPERATION) ||
                                        (cmd_in.code == CMD_VNUM_FMT)));

  // Every request is answered one cycle later; while busy all are refused.
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      resp_valid_ff <= 1'b0;
      resp_err_ff <= 1'b0;
      rd_data_ff <= 16'h0000;
      fault_clear_ff <= 1'b0;
    end else if (ce_in) begin
      resp_valid_ff <= cmd_in.wr || cmd_in.rd;
      resp_err_ff <= (cmd_in.wr || cmd_in.rd) && !req_ok;
      fault_clear_ff <= do_clear;
      if (idle && cmd_in.rd && !cmd_in.wr) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: strap settle, factory load, power-up user restore, store waits.
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_ff <= ST_INIT;
      init_cnt_ff <= 3'h0;
      wait_cnt_ff <= '0;
      strap_ff <= 16'h0000;
    end else if (ce_in) begin
      case (state_ff)
        ST_INIT: begin
          strap_ff <= strap_sync_ff;
          init_cnt_ff <= init_cnt_ff + 3'h1;
          if (init_cnt_ff == SYNC_SETTLE_CYC) begin
            state_ff <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_ff <= ST_WAIT;
          wait_cnt_ff <= WAIT_LAST;
        end
        ST_IDLE: begin
          if (nv_go) begin
            state_ff <= ST_WAIT;
            wait_cnt_ff <= WAIT_LAST;
          end
        end
        ST_WAIT: begin
          if (wait_cnt_ff == '0) begin
            state_ff <= ST_IDLE;
          end else begin
            wait_cnt_ff <= wait_cnt_ff - WAIT_W'(1);
          end
        end
        default: state_ff <= ST_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration words and the two stores. Stores live in flip-flops, so a
  // reset empties the user store; the factory image is rebuilt from the strap.
  always_comb begin
    factory[FLD_ONOFF] = ONOFF_FACTORY;
    factory[FLD_VNOM] = strap_ff;
    factory[FLD_VTRIM] = OFFSET_FACTORY;
    factory[FLD_VCAL] = OFFSET_FACTORY;
    factory[FLD_VBOUND] = ceiling;
  end

  for (genvar i = 0; i < NUM_FLD; i++) begin : g_fld
    always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
        live_ff[i] <= 16'h0000;
        changed_ff[i] <= 1'b0;
      end else if (ce_in) begin
        if (state_ff == ST_LOAD) begin
          live_ff[i] <= usr_valid_ff[i] ? usr_ff[i] : factory[i];
          changed_ff[i] <= 1'b0;
        end else if (do_restore_def) begin
          live_ff[i] <= def_ff[i];
          changed_ff[i] <= 1'b0;
        end else if (do_restore_usr) begin
          if (usr_valid_ff[i]) begin
            live_ff[i] <= usr_ff[i];
          end
          changed_ff[i] <= 1'b0;
        end else if (wr_fld && (fld_idx == 3'(i))) begin
          live_ff[i] <= (i == FLD_ONOFF) ? (cmd_in.data & ONOFF_MASK) : cmd_in.data;
          changed_ff[i] <= 1'b1;
        end
      end
    end

    always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
        def_ff[i] <= 16'h0000;
        usr_ff[i] <= 16'h0000;
        usr_valid_ff[i] <= 1'b0;
      end else if (ce_in) begin
        if (state_ff == ST_LOAD) begin
          def_ff[i] <= factory[i];
        end else if (do_store_def) begin
          def_ff[i] <= live_ff[i];
        end
        if (do_store_usr && changed_ff[i]) begin
          usr_ff[i] <= live_ff[i];
          usr_valid_ff[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      op_ff <= OPERATION_RST;
      sec_ff <= SEC_LEVEL_RST;
    end else if (ce_in) begin
      if (wr_op) begin
        op_ff <= cmd_in.data[7:0];
      end
      if ((state_ff == ST_LOAD) || do_restore_usr) begin
        sec_ff <= SEC_LEVEL_USER;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Run decision from the pin and the operation byte.
  assign pin_en = (ctrl_sync_ff == live_ff[FLD_ONOFF][ONOFF_POL_BIT]);
  assign pin_off = live_ff[FLD_ONOFF][ONOFF_PIN_BIT] && !pin_en;
  assign bus_off = live_ff[FLD_ONOFF][ONOFF_BUS_BIT] &&
                   (op_ff[OP_EN_HI:OP_EN_LO] != OP_ON);
  assign want_run = !live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] || (!pin_off && !bus_off);
  assign nxt_fast = (pin_off && live_ff[FLD_ONOFF][ONOFF_ACT_BIT]) ||
                    (bus_off && (op_ff[OP_EN_HI:OP_EN_LO] == OP_OFF_NOW));

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      run_ff <= 1'b0;
      fast_off_ff <= 1'b0;
    end else if (ce_in) begin
      run_ff <= active && want_run;
      fast_off_ff <= active && !want_run && nxt_fast;
    end
  end

  pol_vout_calc u_calc (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .vnom_in(live_ff[FLD_VNOM]),
    .trim_in(live_ff[FLD_VTRIM]),
    .cal_in(live_ff[FLD_VCAL]),
    .vbound_in(live_ff[FLD_VBOUND]),
    .strap_in(strap_ff),
    .target_out(target),
    .ceiling_out(ceiling)
  );

  assign ctl_out = '{run: run_ff, fast_off: fast_off_ff, target: target};
  assign resp_valid_out = resp_valid_ff;
  assign resp_err_out = resp_err_ff;
  assign rd_data_out = rd_data_ff;
  assign busy_out = !idle;
  assign fault_clear_out = fault_clear_ff;
  assign security_level_out = sec_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  always_run_a:
    assert property (ce_in && active && !live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] |=> run_ff)
      else $error("run not held with power-up bit clear");
  bus_gate_a:
    assert property (ce_in && live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] &&
                     live_ff[FLD_ONOFF][ONOFF_BUS_BIT] && op_ff[OP_EN_HI:OP_EN_LO] != OP_ON
                     |=> !run_ff)
      else $error("ran without operation enable");
  pin_polarity_a:
    assert property (ce_in && active && live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] &&
                     !live_ff[FLD_ONOFF][ONOFF_BUS_BIT] && live_ff[FLD_ONOFF][ONOFF_PIN_BIT]
                     |=> run_ff == $past(ctrl_sync_ff == live_ff[FLD_ONOFF][ONOFF_POL_BIT]))
      else $error("run does not follow pin with polarity");
  pin_fast_off_a:
    assert property (ce_in && active && live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] &&
                     live_ff[FLD_ONOFF][ONOFF_PIN_BIT] && !pin_en
                     |=> !run_ff && fast_off_ff == $past(live_ff[FLD_ONOFF][ONOFF_ACT_BIT]))
      else $error("pin off action wrong");
  op_off_now_a:
    assert property (ce_in && active && live_ff[FLD_ONOFF][ONOFF_PWRUP_BIT] &&
                     live_ff[FLD_ONOFF][ONOFF_BUS_BIT] && op_ff[OP_EN_HI:OP_EN_LO] == OP_OFF_NOW
                     |=> fast_off_ff)
      else $error("immediate off not fast");
  fault_clear_a:
    assert property (ce_in && idle && cmd_in.wr && cmd_in.code == CMD_CLEAR_FAULTS
                     |=> fault_clear_out && !resp_err_out)
      else $error("clear faults pulse missing");
  store_default_a:
    assert property (ce_in && do_store_def |=> def_ff[FLD_VNOM] == $past(live_ff[FLD_VNOM]))
      else $error("default store not written");
  restore_default_a:
    assert property (ce_in && do_restore_def |=> live_ff[FLD_VCAL] == $past(def_ff[FLD_VCAL]))
      else $error("default restore not applied");
  store_user_a:
    assert property (ce_in && do_store_usr && changed_ff[FLD_VTRIM]
                     |=> usr_ff[FLD_VTRIM] == $past(live_ff[FLD_VTRIM]))
      else $error("changed word not saved to user store");
  nv_wait_a:
    assert property (ce_in && nv_go |=> busy_out [*2])
      else $error("store wait too short");
  busy_refuse_a:
    assert property (ce_in && !idle && (cmd_in.wr || cmd_in.rd) |=> resp_valid_out && resp_err_out)
      else $error("request accepted while busy");
  user_security_a:
    assert property (ce_in && do_restore_usr |=> security_level_out == SEC_LEVEL_USER && busy_out)
      else $error("security level not set");
  format_read_a:
    assert property (ce_in && idle && cmd_in.rd && !cmd_in.wr && cmd_in.code == CMD_VNUM_FMT
                     |=> rd_data_out[7:5] == VNUM_FMT &&
                         (VNUM_FMT != FMT_DIRECT || rd_data_out[4:0] == FMT_DIRECT_LOW))
      else $error("format byte wrong");
  nominal_write_a:
    assert property (ce_in && idle && cmd_in.wr && cmd_in.code == CMD_VNOM
                     |=> live_ff[FLD_VNOM] == $past(cmd_in.data))
      else $error("nominal target not written");
  bound_refuse_a:
    assert property (ce_in && idle && cmd_in.wr && cmd_in.code == CMD_VBOUND &&
                     cmd_in.data > ceiling |=> $stable(live_ff[FLD_VBOUND]) && resp_err_out)
      else $error("bound above ceiling accepted");
  target_clamp_a:
    assert property (ce_in |=> target <= $past(live_ff[FLD_VBOUND]))
      else $error("target above upper bound");

  store_user_c: cover property (ce_in && do_store_usr);
  run_drop_c: cover property (ce_in && active ##1 $fell(run_ff));
  refused_c: cover property (resp_valid_out && resp_err_out);
endmodule : pol_onoff_vout_top
`default_nettype wire

// *** bench/pol_host_model.sv ***
// Host model that sends decoded bus commands and keeps the host's wait times.
`default_nettype none
module pol_host_model
  import pol_pkg::*;
#(
  parameter int WAIT_CYC = 8
) (
  // Clock.
  input wire logic mclk_in,
  // Command port.
  output pol_cmd_t cmd_out,
  input wire logic resp_valid_in,
  input wire logic resp_err_in,
  input wire logic [15:0] rd_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd_out = '0;
  // One request, then the answer; unanswered requests return unknowns.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic e, output logic [15:0] q);
    @(posedge mclk_in);
    cmd_out <= {w, !w, c, d};
    @(posedge mclk_in);
    cmd_out <= '0;
    e = 1'bx;
    q = 16'hxxxx;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      if (resp_valid_in === 1'b1) begin
        e = resp_err_in;
        q = rd_data_in;
        break;
      end
    end
    if (w && c inside {CMD_STORE_DEF, CMD_RESTORE_DEF, CMD_STORE_USER, CMD_RESTORE_USER})
      repeat (WAIT_CYC + 2) @(posedge mclk_in);
  endtask : xfer
endmodule : pol_host_model
`default_nettype wire

// *** bench/pmbus_onoff_and_vout_setpoint_test.sv ***
// Self-checking bench for the on/off, store and output setpoint block.
`default_nettype none
module pmbus_onoff_and_vout_setpoint_test;
  import pol_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT_CYC = 8;
  typedef struct packed {
    logic w;
    logic [7:0] c;
    logic [15:0] d;
    logic e;
    logic [15:0] q;
    logic [15:0] t;
  } pol_row_t;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ctrl_pin = 1'b0;
  logic ce = 1'b1;
  pol_cmd_t cmd;
  pol_ctl_t ctl;
  logic resp_valid, resp_err, busy, fclr, e;
  logic [15:0] rd_data, q;
  logic [1:0] sec;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_fc = 0;
  pol_row_t rows [16] = '{
    '{1'b0, 8'h20, 16'h0, 1'b0, {8'h00, FMT_LINEAR, 5'h13}, 16'h1000},
    '{1'b0, 8'h21, 16'h0, 1'b0, 16'h1000, 16'h1000},
    '{1'b0, 8'h24, 16'h0, 1'b0, 16'h1199, 16'h1000},
    '{1'b1, 8'h20, 16'h5, 1'b1, 16'h0, 16'h1000},
    '{1'b1, 8'h24, 16'h119a, 1'b1, 16'h0, 16'h1000},
    '{1'b0, 8'h24, 16'h0, 1'b0, 16'h1199, 16'h1000},
    '{1'b1, 8'h21, 16'h1200, 1'b0, 16'h0, 16'h1199},
    '{1'b1, 8'h21, 16'h0800, 1'b0, 16'h0, 16'h0800},
    '{1'b1, 8'h22, 16'h0010, 1'b0, 16'h0, 16'h0810},
    '{1'b1, 8'h23, 16'hfff0, 1'b0, 16'h0, 16'h0800},
    '{1'b0, 8'h22, 16'h0, 1'b0, 16'h0010, 16'h0800},
    '{1'b0, 8'h99, 16'h0, 1'b1, 16'h0, 16'h0800},
    '{1'b0, 8'h03, 16'h0, 1'b1, 16'h0, 16'h0800},
    '{1'b1, 8'h02, 16'h00e0, 1'b0, 16'h0, 16'h0800},
    '{1'b0, 8'h02, 16'h0, 1'b0, 16'h0000, 16'h0800},
    '{1'b0, 8'h01, 16'h0, 1'b0, 16'h0080, 16'h0800}};
  // Columns: config, operation, pin, run, fast off.
  logic [18:0] oo [9] = '{
    {8'h00, 8'h00, 3'b010}, {8'h18, 8'h80, 3'b010}, {8'h18, 8'h40, 3'b000},
    {8'h18, 8'h00, 3'b001}, {8'h10, 8'h00, 3'b010}, {8'h14, 8'h00, 3'b010},
    {8'h14, 8'h00, 3'b100}, {8'h17, 8'h00, 3'b110}, {8'h17, 8'h00, 3'b001}};
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  pol_onoff_vout_top #(.NV_WAIT_CYCLES(WAIT_CYC)) i_pol_onoff_vout_top (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce), .cmd_in(cmd),
    .resp_valid_out(resp_valid), .resp_err_out(resp_err), .rd_data_out(rd_data),
    .busy_out(busy), .ctrl_pin_in(ctrl_pin), .voltage_select_strap_in(16'h1000),
    .ctl_out(ctl), .fault_clear_out(fclr), .security_level_out(sec));
  pol_host_model #(.WAIT_CYC(WAIT_CYC)) i_pol_host_model (
    .mclk_in(mclk_in), .cmd_out(cmd), .resp_valid_in(resp_valid),
    .resp_err_in(resp_err), .rd_data_in(rd_data));
  ////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string n, input logic x, input logic g);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %b got %b", n, x, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string n, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk_word
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (fclr === 1'b1) n_fc <= n_fc + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wait_ready();
    for (int i = 0; i < 100; i++) begin
      @(posedge mclk_in);
      if (busy === 1'b0) break;
    end
  endtask : wait_ready
  initial begin
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    wait_ready();
    chk_word("security", 16'h0001, {14'h0, sec});
    chk_word("target", 16'h1000, ctl.target);
    foreach (rows[i]) begin
      i_pol_host_model.xfer(rows[i].w, rows[i].c, rows[i].d, e, q);
      chk_bit("resp_err", rows[i].e, e);
      if (!rows[i].w && !rows[i].e) chk_word("rd_data", rows[i].q, q);
      repeat (2) @(posedge mclk_in);
      chk_word("target", rows[i].t, ctl.target);
    end
    foreach (oo[i]) begin
      ctrl_pin <= oo[i][2];
      i_pol_host_model.xfer(1'b1, CMD_ONOFF_CFG, {8'h00, oo[i][18:11]}, e, q);
      i_pol_host_model.xfer(1'b1, CMD_OPERATION, {8'h00, oo[i][10:3]}, e, q);
      repeat (5) @(posedge mclk_in);
      chk_bit("run", oo[i][1], ctl.run);
      chk_bit("fast_off", oo[i][0], ctl.fast_off);
    end
    i_pol_host_model.xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0, e, q);
    repeat (2) @(posedge mclk_in);
    chk_word("clear pulses", 16'h0001, n_fc[15:0]);
    i_pol_host_model.xfer(1'b1, CMD_VNOM, 16'h0900, e, q);
    i_pol_host_model.xfer(1'b1, CMD_STORE_USER, 16'h0, e, q);
    i_pol_host_model.xfer(1'b1, CMD_VNOM, 16'h0a00, e, q);
    i_pol_host_model.xfer(1'b1, CMD_RESTORE_USER, 16'h0, e, q);
    i_pol_host_model.xfer(1'b0, CMD_VNOM, 16'h0, e, q);
    chk_word("user nominal", 16'h0900, q);
    chk_word("security", 16'h0001, {14'h0, sec});
    // A new write and a second store update the user store; a restore then undoes a later write.
    i_pol_host_model.xfer(1'b1, CMD_VTRIM, 16'h0020, e, q);
    i_pol_host_model.xfer(1'b1, CMD_STORE_USER, 16'h0, e, q);
    i_pol_host_model.xfer(1'b1, CMD_VTRIM, 16'h0030, e, q);
    i_pol_host_model.xfer(1'b1, CMD_RESTORE_USER, 16'h0, e, q);
    i_pol_host_model.xfer(1'b0, CMD_VTRIM, 16'h0, e, q);
    chk_word("user trim", 16'h0020, q);
    i_pol_host_model.xfer(1'b1, CMD_STORE_DEF, 16'h0, e, q);
    i_pol_host_model.xfer(1'b1, CMD_VNOM, 16'h0b00, e, q);
    i_pol_host_model.xfer(1'b1, CMD_RESTORE_DEF, 16'h0, e, q);
    i_pol_host_model.xfer(1'b0, CMD_VNOM, 16'h0, e, q);
    chk_word("default nominal", 16'h0900, q);
    // With the clock enable low the pin change must not reach the run level.
    ce <= 1'b0;
    ctrl_pin <= 1'b1;
    repeat (5) @(posedge mclk_in);
    chk_bit("frozen run", 1'b0, ctl.run);
    ce <= 1'b1;
    repeat (5) @(posedge mclk_in);
    chk_bit("run", 1'b1, ctl.run);
    chk_bit("fast_off", 1'b0, ctl.fast_off);
    // A second reset empties the user store and refuses early requests.
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    chk_bit("busy in reset", 1'b1, busy);
    chk_word("security in reset", 16'h0000, {14'h0, sec});
    resetn_in <= 1'b1;
    i_pol_host_model.xfer(1'b0, CMD_VNOM, 16'h0, e, q);
    chk_bit("early refused", 1'b1, e);
    wait_ready();
    chk_word("security", 16'h0001, {14'h0, sec});
    chk_word("strap target", 16'h1000, ctl.target);
    chk_bit("run", 1'b1, ctl.run);
    print_verdict();
  end
endmodule : pmbus_onoff_and_vout_setpoint_test
`default_nettype wire
